// ===== hw/t8p_pkg.sv
// constants of the 8-bit timer with shared prescaler
// assumes a single AHB-Lite slave port and one clock domain
package t8p_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_TIMER_COUNT  = 8'h00;
    localparam logic [7:0] OFS_INTR_CONTROL = 8'h04;
    localparam logic [7:0] OFS_OPTION       = 8'h08;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned OPT_PULLUP_DIS_BIT = 7;
    localparam int unsigned OPT_IRQ_EDGE_BIT   = 6;
    localparam int unsigned OPT_SOURCE_BIT     = 5;
    localparam int unsigned OPT_EDGE_BIT       = 4;
    localparam int unsigned OPT_TO_WDT_BIT     = 3;
    localparam int unsigned OPT_RATE_MSB       = 2;
    localparam int unsigned OPT_RATE_LSB       = 0;
    localparam int unsigned RATE_W             = 3;
    localparam int unsigned INTC_IRQ_EN_BIT    = 5;
    localparam int unsigned INTC_FLAG_BIT      = 2;
    localparam int unsigned HTRANS_ACTIVE_BIT  = 1;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0]  OPTION_RESET   = 8'hFF;
    localparam logic [7:0]  COUNT_RESET    = 8'h00;
    localparam logic [7:0]  COUNT_WRAP     = 8'hFF;
    localparam logic [1:0]  HOLDOFF_CYCLES = 2'h2;
    localparam logic [1:0]  PHASE_TWO      = 2'h1;
    localparam logic [1:0]  PHASE_FOUR     = 2'h3;
    localparam logic [31:0] READ_UNMAPPED  = 32'h0000_0000;

    typedef enum logic [1:0] {
        T8P_SEL_NONE   = 2'b00,
        T8P_SEL_COUNT  = 2'b01,
        T8P_SEL_INTC   = 2'b10,
        T8P_SEL_OPTION = 2'b11
    } t8p_sel_t;

endpackage

// ===== hw/t8p_presc_if.sv
// link between the timer core and its shared prescaler
// assumes both ends run on hclk
`timescale 1ns/1ps
interface t8p_presc_if;
    logic                      in_pulse;
    logic                      clear;
    logic                      to_wdt;
    logic [t8p_pkg::RATE_W-1:0] rate;
    logic                      out_pulse;

    modport owner (output in_pulse, output clear, output to_wdt, output rate, input out_pulse);
    modport presc (input in_pulse, input clear, input to_wdt, input rate, output out_pulse);
endinterface

// ===== hw/t8p_prescaler.sv
// programmable power-of-two prescaler shared by timer and watchdog
// assumes in_pulse and clear are one-cycle pulses on hclk
`timescale 1ns/1ps
module t8p_prescaler #(
    parameter int unsigned PRESC_W = 8
) (
    input wire logic         hclk,
    input wire logic         hresetn,
    t8p_presc_if.presc       pif
);
    typedef struct packed {
        logic [PRESC_W-1:0] cnt;
    } t8p_presc_state_t;

    t8p_presc_state_t   st_reg;
    t8p_presc_state_t   st_next;
    logic [3:0]         div_log2;
    logic [PRESC_W-1:0] div_mask;

    // ------------------------------------------------------------
    // rate decode
    // ------------------------------------------------------------
    // (R3) watchdog one step faster
    assign div_log2 = pif.to_wdt ? {1'b0, pif.rate} : 4'({1'b0, pif.rate} + 4'h1);
    assign div_mask = PRESC_W'((9'h001 << div_log2) - 9'h001);
    assign pif.out_pulse = pif.in_pulse && (((st_reg.cnt + PRESC_W'(1)) & div_mask) == '0);

    always_comb begin
        st_next = st_reg;
        // (R6) (R7) clear beats count
        if (pif.clear) begin
            st_next.cnt = '0;
        end else if (pif.in_pulse) begin
            st_next.cnt = st_reg.cnt + PRESC_W'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    presc_clear_a : assert property (@(posedge hclk) disable iff (!hresetn) // (R6)
        pif.clear |=> st_reg.cnt == '0)
        else $error("prescaler not cleared");

    wdt_bypass_a : assert property (@(posedge hclk) disable iff (!hresetn) // (R3)
        (pif.in_pulse && pif.to_wdt && pif.rate == '0) |-> pif.out_pulse)
        else $error("watchdog 1:1 rate lost a pulse");
endmodule

// ===== hw/t8p_timer.sv
// 8-bit timer/counter with prescaler shared with the watchdog, AHB-Lite slave
// assumes hready is the one slave's hreadyout; ext_count_pin is asynchronous
//
// Summary of operation
// (R1) one prescaler serves either timer or watchdog, never both
// (R2) assignment bit set routes prescaler to watchdog, clear to timer
// (R3) rate field gives timer 1:2..1:256, watchdog 1:1..1:128
// (R4) timer counts undivided only while prescaler serves the watchdog
// (R5) prescaler count is neither readable nor writable
// (R6) writing timer count clears prescaler when prescaler serves timer
// (R7) watchdog clear instruction clears prescaler when it serves watchdog
// (R8) wrap from FFh to 00h requests timer interrupt
// (R9) overflow flag sets on every wrap regardless of enable
// (R10) software clears overflow flag; hardware never does
// (R11) interrupt raised only when flag and enable both set
// (R12) timer frozen during sleep
// (R13) counter increments sampled on phase clocks two and four
// (R14) source bit picks pin edges when set, instruction clock when clear
// (R15) edge bit picks falling edges when set, rising when clear
// (R16) option also holds pull-up disable and external interrupt edge
// (R17) software order for moving prescaler to watchdog
// (R18) software order for moving prescaler to timer
// (R19) timer mode without prescaler counts once per instruction cycle
// (R20) increments held off two instruction cycles after count write
// (R21) count advances on prescaler output, else on each source event
// (R22) option register resets to all ones
`timescale 1ns/1ps
module t8p_timer (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        ext_count_pin,
    input  wire logic        sleep_mode,
    input  wire logic        watchdog_clear_instr,
    input  wire logic        wdt_clk_tick,
    output logic             timer_irq,
    output logic             port_pullup_disable,
    output logic             ext_irq_edge_sel,
    output logic             watchdog_tick
);
    typedef struct packed {
        logic [7:0]  count;
        logic [7:0]  option;
        logic        ovf_flag;
        logic        ovf_en;
        logic [1:0]  phase;
        logic [1:0]  holdoff;
        logic        pend;
        logic [2:0]  sync;
        logic        dph_wr;
        logic [7:0]  dph_addr;
        logic [31:0] rdata;
        logic        readyout;
        logic        irq;
        logic        pullup_dis;
        logic        irq_edge;
        logic        wdt_tick;
    } t8p_state_t;

    localparam t8p_state_t STATE_RESET = '{
        count: t8p_pkg::COUNT_RESET, option: t8p_pkg::OPTION_RESET,
        ovf_flag: 1'b0, ovf_en: 1'b0, phase: 2'h0, holdoff: 2'h0, pend: 1'b0,
        sync: 3'h0, dph_wr: 1'b0, dph_addr: 8'h00, rdata: 32'h0000_0000,
        readyout: 1'b1, irq: 1'b0, pullup_dis: 1'b1, irq_edge: 1'b1, wdt_tick: 1'b0};

    t8p_state_t  st_reg;
    t8p_state_t  st_next;
    t8p_presc_if pif ();

    logic to_wdt;
    logic src_evt;
    logic edge_evt;
    logic raw_evt;
    logic sample_phase;
    logic inc;
    logic count_wr;
    logic addr_take;
    logic ovf_set;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    // upper address bits ignored: the map aliases every 256 bytes
    function automatic t8p_pkg::t8p_sel_t reg_sel(input logic [7:0] addr);
        unique case (addr)
            t8p_pkg::OFS_TIMER_COUNT:  reg_sel = t8p_pkg::T8P_SEL_COUNT;
            t8p_pkg::OFS_INTR_CONTROL: reg_sel = t8p_pkg::T8P_SEL_INTC;
            t8p_pkg::OFS_OPTION:       reg_sel = t8p_pkg::T8P_SEL_OPTION;
            default:                   reg_sel = t8p_pkg::T8P_SEL_NONE;
        endcase
    endfunction

    // (R5) no prescaler word in the map
    function automatic logic [31:0] reg_read(input t8p_pkg::t8p_sel_t sel, input t8p_state_t s);
        logic [31:0] v;
        v = t8p_pkg::READ_UNMAPPED;
        unique case (sel)
            t8p_pkg::T8P_SEL_COUNT:  v[7:0] = s.count;
            t8p_pkg::T8P_SEL_OPTION: v[7:0] = s.option;
            t8p_pkg::T8P_SEL_INTC: begin
                v[t8p_pkg::INTC_IRQ_EN_BIT] = s.ovf_en;
                v[t8p_pkg::INTC_FLAG_BIT]   = s.ovf_flag;
            end
            t8p_pkg::T8P_SEL_NONE:   v = t8p_pkg::READ_UNMAPPED;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // source selection and prescaler routing
    // ------------------------------------------------------------
    // (R2) assignment bit
    assign to_wdt       = st_reg.option[t8p_pkg::OPT_TO_WDT_BIT];
    assign sample_phase = (st_reg.phase == t8p_pkg::PHASE_TWO) || (st_reg.phase == t8p_pkg::PHASE_FOUR);
    // (R15) edge polarity, read past the first sync stage only
    assign edge_evt     = st_reg.option[t8p_pkg::OPT_EDGE_BIT] ? (st_reg.sync[2] & ~st_reg.sync[1])
                                                              : (st_reg.sync[1] & ~st_reg.sync[2]);
    // (R14) (R19) pin edges or one tick per instruction cycle
    assign src_evt      = st_reg.option[t8p_pkg::OPT_SOURCE_BIT] ? edge_evt
                                                                : (st_reg.phase == t8p_pkg::PHASE_FOUR);
    // (R1) prescaler input is one source or the other
    assign pif.in_pulse = to_wdt ? wdt_clk_tick : (src_evt & ~sleep_mode);
    assign pif.to_wdt   = to_wdt;
    assign pif.rate     = st_reg.option[t8p_pkg::OPT_RATE_MSB:t8p_pkg::OPT_RATE_LSB];
    // (R4) (R21) bypass when the watchdog owns the prescaler
    assign raw_evt      = to_wdt ? src_evt : pif.out_pulse;
    assign count_wr     = st_reg.dph_wr && (reg_sel(st_reg.dph_addr) == t8p_pkg::T8P_SEL_COUNT);
    // (R6) (R7) clear follows the owner
    assign pif.clear    = (count_wr & ~to_wdt) | (watchdog_clear_instr & to_wdt);
    // (R12) (R13) (R20) sampled increment, frozen in sleep and holdoff
    assign inc          = (st_reg.pend | raw_evt) & sample_phase & ~sleep_mode & (st_reg.holdoff == 2'h0);
    // (R8) (R9) wrap sets the flag regardless of enable
    assign ovf_set      = inc && (st_reg.count == t8p_pkg::COUNT_WRAP);
    assign addr_take    = hsel & htrans[t8p_pkg::HTRANS_ACTIVE_BIT] & hready;

    t8p_prescaler #(
        .PRESC_W (8)
    ) u_presc (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pif     (pif.presc)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next          = st_reg;
        st_next.phase    = st_reg.phase + 2'h1;
        st_next.sync     = {st_reg.sync[1:0], ext_count_pin};
        st_next.readyout = 1'b1;

        // events between sample points wait for phase two or four
        if (sleep_mode) begin
            st_next.pend = st_reg.pend;
        end else if (sample_phase) begin
            st_next.pend = 1'b0;
        end else begin
            st_next.pend = st_reg.pend | raw_evt;
        end

        // (R20) holdoff counts instruction cycles
        if ((st_reg.phase == t8p_pkg::PHASE_FOUR) && (st_reg.holdoff != 2'h0)) begin
            st_next.holdoff = st_reg.holdoff - 2'h1;
        end

        if (inc) begin
            st_next.count = st_reg.count + 8'h01;
        end

        // data phase of a write: the bus beats a same-cycle increment
        if (st_reg.dph_wr) begin
            unique case (reg_sel(st_reg.dph_addr))
                t8p_pkg::T8P_SEL_COUNT: begin
                    st_next.count   = hwdata[7:0];
                    st_next.holdoff = t8p_pkg::HOLDOFF_CYCLES;
                end
                t8p_pkg::T8P_SEL_INTC: begin
                    st_next.ovf_en   = hwdata[t8p_pkg::INTC_IRQ_EN_BIT];
                    // (R10) software writes the flag
                    st_next.ovf_flag = hwdata[t8p_pkg::INTC_FLAG_BIT];
                end
                t8p_pkg::T8P_SEL_OPTION: st_next.option = hwdata[7:0];
                t8p_pkg::T8P_SEL_NONE:   st_next.option = st_reg.option;
            endcase
        end

        // (R9) set wins over a software clear
        if (ovf_set) begin
            st_next.ovf_flag = 1'b1;
        end

        st_next.dph_wr   = addr_take & hwrite;
        st_next.dph_addr = haddr[7:0];
        // read from next state so a read right behind a write sees it
        if (addr_take && !hwrite) begin
            st_next.rdata = reg_read(reg_sel(haddr[7:0]), st_next);
        end

        // (R11) interrupt gated by enable
        st_next.irq        = st_next.ovf_flag & st_next.ovf_en;
        // (R16) bits for neighbouring blocks
        st_next.pullup_dis = st_next.option[t8p_pkg::OPT_PULLUP_DIS_BIT];
        st_next.irq_edge   = st_next.option[t8p_pkg::OPT_IRQ_EDGE_BIT];
        st_next.wdt_tick   = to_wdt ? pif.out_pulse : wdt_clk_tick;
    end

    // (R22) option resets to all ones
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= STATE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hrdata              = st_reg.rdata;
    assign hreadyout           = st_reg.readyout;
    assign hresp               = 1'b0;
    assign timer_irq           = st_reg.irq;
    assign port_pullup_disable = st_reg.pullup_dis;
    assign ext_irq_edge_sel    = st_reg.irq_edge;
    assign watchdog_tick       = st_reg.wdt_tick;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking t8p_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    wrap_flag_a : assert property ((ovf_set && !count_wr) |=> st_reg.ovf_flag && st_reg.count == 8'h00) // (R8)
        else $error("wrap did not set flag");

    irq_gate_a : assert property (timer_irq |-> st_reg.ovf_en && st_reg.ovf_flag) // (R11)
        else $error("interrupt without enable and flag");

    sleep_freeze_a : assert property ((sleep_mode && !count_wr) |=> st_reg.count == $past(st_reg.count)) // (R12)
        else $error("count moved in sleep");

    write_holdoff_a : assert property (count_wr |=> !inc [*5]) // (R20)
        else $error("increment inside holdoff");

    phase_sample_a : assert property (inc |-> sample_phase) // (R13)
        else $error("increment off phase two or four");

    wdt_clear_a : assert property ((watchdog_clear_instr && to_wdt) |-> pif.clear) // (R7)
        else $error("watchdog clear missed prescaler");

    bypass_a : assert property ( // (R4)
        (to_wdt && src_evt && sample_phase && !sleep_mode && st_reg.holdoff == 2'h0)
            |=> st_reg.count == $past(st_reg.count) + 8'h01 || $past(count_wr))
        else $error("undivided count missed");

    owner_path_a : assert property (!to_wdt |-> pif.in_pulse == (src_evt && !sleep_mode)) // (R1)
        else $error("prescaler fed by wrong owner");

    flag_hold_a : assert property ((st_reg.ovf_flag && !st_reg.dph_wr) |=> st_reg.ovf_flag) // (R10)
        else $error("flag cleared by hardware");

    flag_source_a : assert property ( // (R9)
        $rose(st_reg.ovf_flag) |-> $past(ovf_set) || $past(st_reg.dph_wr))
        else $error("flag rose without wrap or write");

    count_write_a : assert property ( // (R20)
        count_wr |=> st_reg.count == $past(hwdata[7:0]))
        else $error("count write lost");

    count_step_a : assert property ( // (R19)
        !count_wr |=> st_reg.count == $past(st_reg.count) || st_reg.count == $past(st_reg.count) + 8'h01)
        else $error("count jumped");

    option_write_a : assert property ( // (R2)
        (st_reg.dph_wr && reg_sel(st_reg.dph_addr) == t8p_pkg::T8P_SEL_OPTION)
            |=> st_reg.option == $past(hwdata[7:0]))
        else $error("option write lost");

    timer_clear_a : assert property ( // (R6)
        (count_wr && !to_wdt) |-> pif.clear)
        else $error("count write missed prescaler");

    wdt_feed_a : assert property ( // (R1)
        to_wdt |-> pif.in_pulse == wdt_clk_tick)
        else $error("watchdog ticks not fed to prescaler");

    wdt_pass_a : assert property ( // (R2)
        !to_wdt |=> watchdog_tick == $past(wdt_clk_tick))
        else $error("watchdog tick not passed through");

    sleep_presc_a : assert property ( // (R12)
        (sleep_mode && !to_wdt) |-> !pif.in_pulse)
        else $error("prescaler ran in sleep");

    presc_route_a : assert property ( // (R21)
        (!to_wdt && inc && !st_reg.pend) |-> pif.out_pulse)
        else $error("timer stepped without prescaler output");
endmodule

// ===== tb/t8p_timer_test.sv
// self-checking bench for the 8-bit timer with shared prescaler
// assumes the timer is the only AHB-Lite slave, so hready is its own hreadyout
`timescale 1ns/1ps
`define CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module t8p_timer_test;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        ext_count_pin;
    logic        sleep_mode;
    logic        watchdog_clear_instr;
    logic        wdt_clk_tick;
    logic        timer_irq;
    logic        port_pullup_disable;
    logic        ext_irq_edge_sel;
    logic        watchdog_tick;
    logic [31:0] rd;
    int          n_errors;
    int          num_checks;
    int          wd_seen;

    assign hready = hreadyout;

    t8p_timer i_t8p_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ext_count_pin(ext_count_pin), .sleep_mode(sleep_mode),
        .watchdog_clear_instr(watchdog_clear_instr), .wdt_clk_tick(wdt_clk_tick), .timer_irq(timer_irq),
        .port_pullup_disable(port_pullup_disable), .ext_irq_edge_sel(ext_irq_edge_sel),
        .watchdog_tick(watchdog_tick));

    // ------------------------------------------------------------
    // clock, watchdog tick monitor, hang guard
    // ------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        if (watchdog_tick === 1'b1) wd_seen++;
    end

    initial begin
        repeat (40000) @(posedge hclk);
        n_errors++;
        finish_test();
    end

    // ------------------------------------------------------------
    // bus and stimulus helpers, all entered just after a rising edge
    // ------------------------------------------------------------
    task automatic ahb_write(input logic [7:0] a, input logic [7:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= 1'b1;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (hready !== 1'b1);
    endtask

    task automatic ahb_read(input logic [7:0] a, output logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= 1'b0;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        do @(posedge hclk); while (hready !== 1'b1);
        d = hrdata;
        `CHECK(hresp, 1'b0);
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // pulses slow enough for the 3-flop synchroniser and the phase sampling
    task automatic pin_pulses(input int n);
        repeat (n) begin
            ext_count_pin <= 1'b1;
            wait_clk(8);
            ext_count_pin <= 1'b0;
            wait_clk(8);
        end
        wait_clk(8);
    endtask

    task automatic wdt_ticks(input int n);
        repeat (n) begin
            wdt_clk_tick <= 1'b1;
            wait_clk(1);
            wdt_clk_tick <= 1'b0;
            wait_clk(3);
        end
        wait_clk(3);
    endtask

    task automatic wdt_clear;
        watchdog_clear_instr <= 1'b1;
        wait_clk(1);
        watchdog_clear_instr <= 1'b0;
        wait_clk(1);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // reset values and option side pins
    task automatic test_reset_and_option;
        `CHECK(port_pullup_disable, 1'b1);
        `CHECK(ext_irq_edge_sel, 1'b1);
        ahb_read(t8p_pkg::OFS_OPTION, rd);
        `CHECK(rd, 32'h000000FF);
        ahb_read(t8p_pkg::OFS_INTR_CONTROL, rd);
        `CHECK(rd, 32'h00000000);
        ahb_write(8'h0C, 8'hFF);
        ahb_read(8'h0C, rd);
        `CHECK(rd, 32'h00000000);
        for (int k = 0; k < 4; k++) begin
            ahb_write(t8p_pkg::OFS_OPTION, {k[1:0], 6'h08});
            wait_clk(2);
            `CHECK({port_pullup_disable, ext_irq_edge_sel}, k[1:0]);
        end
        ahb_read(t8p_pkg::OFS_OPTION, rd);
        `CHECK(rd, 32'h000000C8);
    endtask

    // internal clock through each short timer rate
    task automatic test_internal_rates;
        int lo;
        int hi;
        for (int r = 0; r < 5; r++) begin
            // r == 4 stands for the prescaler on the watchdog, timer undivided
            ahb_write(t8p_pkg::OFS_OPTION, (r == 4) ? 8'h08 : r[7:0]);
            ahb_write(t8p_pkg::OFS_TIMER_COUNT, 8'h00);
            wait_clk(512);
            ahb_read(t8p_pkg::OFS_TIMER_COUNT, rd);
            lo = (r == 4) ? 124 : (124 >> (r + 1));
            hi = (r == 4) ? 129 : (129 >> (r + 1));
            `CHECK(rd inside {[lo:hi]}, 1'b1);
        end
    endtask

    // wrap sets sticky flag, irq only when enabled
    task automatic test_overflow;
        ahb_write(t8p_pkg::OFS_OPTION, 8'h08);
        ahb_write(t8p_pkg::OFS_INTR_CONTROL, 8'h00);
        ahb_write(t8p_pkg::OFS_TIMER_COUNT, 8'hFC);
        wait_clk(140);
        ahb_read(t8p_pkg::OFS_INTR_CONTROL, rd);
        `CHECK(rd, 32'h00000004);
        `CHECK(timer_irq, 1'b0);
        ahb_write(t8p_pkg::OFS_INTR_CONTROL, 8'h24);
        wait_clk(2);
        `CHECK(timer_irq, 1'b1);
        ahb_write(t8p_pkg::OFS_INTR_CONTROL, 8'h20);
        wait_clk(2);
        `CHECK(timer_irq, 1'b0);
        ahb_read(t8p_pkg::OFS_INTR_CONTROL, rd);
        `CHECK(rd, 32'h00000020);
        ahb_write(t8p_pkg::OFS_INTR_CONTROL, 8'h00);
    endtask

    task automatic test_sleep;
        ahb_write(t8p_pkg::OFS_OPTION, 8'h08);
        sleep_mode <= 1'b1;
        ahb_write(t8p_pkg::OFS_TIMER_COUNT, 8'h10);
        wait_clk(100);
        ahb_read(t8p_pkg::OFS_TIMER_COUNT, rd);
        `CHECK(rd, 32'h00000010);
        sleep_mode <= 1'b0;
        wait_clk(100);
        ahb_read(t8p_pkg::OFS_TIMER_COUNT, rd);
        `CHECK(rd inside {[32'h22:32'h2A]}, 1'b1);
    endtask

    // pin edges, both polarities, prescaler cleared by count write
    task automatic test_pin_source;
        ahb_write(t8p_pkg::OFS_OPTION, 8'h38);
        ahb_write(t8p_pkg::OFS_TIMER_COUNT, 8'h00);
        wait_clk(12);
        pin_pulses(5);
        ahb_read(t8p_pkg::OFS_TIMER_COUNT, rd);
        `CHECK(rd, 32'h00000005);
        ahb_write(t8p_pkg::OFS_OPTION, 8'h28);
        ahb_write(t8p_pkg::OFS_TIMER_COUNT, 8'h00);
        wait_clk(12);
        pin_pulses(3);
        ahb_read(t8p_pkg::OFS_TIMER_COUNT, rd);
        `CHECK(rd, 32'h00000003);
        ahb_write(t8p_pkg::OFS_OPTION, 8'h31);
        ahb_write(t8p_pkg::OFS_TIMER_COUNT, 8'h00);
        wait_clk(12);
        pin_pulses(3);
        ahb_write(t8p_pkg::OFS_TIMER_COUNT, 8'h00);
        wait_clk(12);
        pin_pulses(3);
        ahb_read(t8p_pkg::OFS_TIMER_COUNT, rd);
        `CHECK(rd, 32'h00000000);
        pin_pulses(1);
        ahb_read(t8p_pkg::OFS_TIMER_COUNT, rd);
        `CHECK(rd, 32'h00000001);
    endtask

    // watchdog side of the shared prescaler
    task automatic test_watchdog_side;
        int base;
        // software order for timer to watchdog hand-over
        wdt_clear();
        ahb_write(t8p_pkg::OFS_TIMER_COUNT, 8'h00);
        ahb_write(t8p_pkg::OFS_OPTION, 8'h39);
        wdt_clear();
        ahb_read(t8p_pkg::OFS_OPTION, rd);
        `CHECK(rd, 32'h00000039);
        for (int r = 0; r < 4; r++) begin
            ahb_write(t8p_pkg::OFS_OPTION, 8'h08 | r[7:0]);
            wdt_clear();
            base = wd_seen;
            wdt_ticks(4 << r);
            `CHECK(wd_seen - base, 4);
        end
        ahb_write(t8p_pkg::OFS_OPTION, 8'h0A);
        wdt_clear();
        base = wd_seen;
        wdt_ticks(3);
        wdt_clear();
        wdt_ticks(3);
        `CHECK(wd_seen - base, 0);
        // watchdog to timer: clear first, then one option write
        wdt_clear();
        ahb_write(t8p_pkg::OFS_OPTION, 8'h07);
        ahb_read(t8p_pkg::OFS_OPTION, rd);
        `CHECK(rd, 32'h00000007);
        base = wd_seen;
        wdt_ticks(4);
        `CHECK(wd_seen - base, 4);
    endtask

    // ------------------------------------------------------------
    // verdict and main sequence
    // ------------------------------------------------------------
    task automatic finish_test;
        if (n_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        hresetn              = 1'b0;
        hsel                 = 1'b0;
        haddr                = 32'h00000000;
        htrans               = 2'b00;
        hwrite               = 1'b0;
        hsize                = 3'h2;
        hwdata               = 32'h00000000;
        ext_count_pin        = 1'b0;
        sleep_mode           = 1'b0;
        watchdog_clear_instr = 1'b0;
        wdt_clk_tick         = 1'b0;
        n_errors             = 0;
        num_checks           = 0;
        wd_seen              = 0;
        wait_clk(16);
        hresetn <= 1'b1;
        wait_clk(1);
        test_reset_and_option();
        test_internal_rates();
        test_overflow();
        test_sleep();
        test_pin_source();
        test_watchdog_side();
        finish_test();
    end
endmodule
